// ---- hdl/serial_latched_sink_driver.sv ----
`timescale 1ns/1ps
// Function
// - Each shift clock rising edge captures the serial input into the first stage.
// - Each further rising edge moves every stage one step toward the cascade output.
// - Sixteen stages, sixteen latches and sixteen sink outputs, one per channel.
// - With latch strobe high the latches follow the shift register continuously.
// - With output enable (low active) high, all sixteen sinks are off.
// - Output enable never changes the latch contents.
// - With output enable low each sink follows its own latch.
// - Cascade output presents the last shift register stage.
module serial_latched_sink_driver (
  input wire logic clk,
  input wire logic rst,
  input wire sink_driver_pkg::pins_s pins,
  output logic [15:0] sink_on,
  output logic ser_out,
  output logic capture_ready
);
  import sink_driver_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and shift clock edge detection.
  // The shift clock is only a sampled level here, so its rising edge is found by
  // comparing the second synchroniser stage with its value one clock earlier.

  pins_s sync1_ff;
  pins_s sync2_ff;
  logic clk_prev_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      clk_prev_ff <= 1'b0;
    end else begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
      clk_prev_ff <= sync2_ff.shift_clk;
    end
  end

  wire shift_edge = sync2_ff.shift_clk & ~clk_prev_ff;
  wire strobe = sync2_ff.latch_strobe;
  wire blank = sync2_ff.out_enable_n;
  logic strobe_prev_ff;
  wire strobe_rise = strobe & ~strobe_prev_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer between captured bits and the shift register.

  logic [BUF_WIDTH-1:0] buf_mem_ff [BUF_DEPTH];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] count_ff;
  logic full_ff;

  // Occupancy at which the buffer refuses a further captured bit.
  function automatic logic buf_is_full(input logic [1:0] occupancy);
    return occupancy == BUF_FULL_COUNT;
  endfunction

  // The shift register stalls for the first strobe cycle so the latches take
  // the word as it stood when the strobe rose; the buffer absorbs any bit
  // that arrives meanwhile.
  wire in_valid = shift_edge;
  wire in_ready = ~full_ff;
  wire drain_ready = ~strobe_rise;
  wire buf_valid = (count_ff != 2'h0);
  wire push = in_valid & in_ready;
  wire pop = buf_valid & drain_ready;
  wire [BUF_WIDTH-1:0] head_bit = buf_mem_ff[rd_ptr_ff];
  wire [1:0] nxt_count = count_ff + {1'b0, push} - {1'b0, pop};
  wire nxt_full = buf_is_full(nxt_count);

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff <= 2'h0;
      full_ff <= 1'b0;
      strobe_prev_ff <= 1'b0;
    end else begin
      strobe_prev_ff <= strobe;
      count_ff <= nxt_count;
      full_ff <= nxt_full;
      if (push) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
    end
  end

  // Only the entry under the write pointer changes, and only on a push.
  always_ff @(posedge clk) begin
    if (rst) begin
      buf_mem_ff[0] <= '0;
      buf_mem_ff[1] <= '0;
    end else if (push) begin
      buf_mem_ff[wr_ptr_ff] <= sync2_ff.ser_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shift register, latches and sink drivers.

  chan_t shift_ff;
  chan_t latch_ff;
  chan_t sink_ff;
  logic ser_out_ff;
  logic ready_ff;

  wire chan_t nxt_shift = pop ? {shift_ff[CHANNELS-2:0], head_bit} : shift_ff;
  // A closed latch ignores the shift register; blanking only gates the sinks.
  wire chan_t nxt_latch = strobe ? shift_ff : latch_ff;
  wire chan_t nxt_sink = blank ? SINK_OFF : latch_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      shift_ff <= SHIFT_RESET;
      ser_out_ff <= 1'b0;
    end else begin
      shift_ff <= nxt_shift;
      ser_out_ff <= nxt_shift[CHANNELS-1];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      latch_ff <= LATCH_RESET;
      sink_ff <= SINK_OFF;
      ready_ff <= 1'b0;
    end else begin
      latch_ff <= nxt_latch;
      sink_ff <= nxt_sink;
      ready_ff <= ~nxt_full;
    end
  end

  assign sink_on = sink_ff;
  assign ser_out = ser_out_ff;
  assign capture_ready = ready_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence shift_rise;
    !clk_prev_ff ##0 sync2_ff.shift_clk ##0 !full_ff;
  endsequence

  sequence popped_bit;
    pop ##1 1'b1;
  endsequence

  buffer_take_a: assert property (shift_rise |=> count_ff != 2'h0)
    else $error("Captured bit did not enter the buffer.");
  first_stage_a: assert property (pop |=> shift_ff[0] == $past(head_bit))
    else $error("First stage did not take the buffered bit.");
  stage_move_a: assert property (popped_bit |-> shift_ff[15:1] == $past(shift_ff[14:0]))
    else $error("Shift register stages did not advance.");
  shift_still_a: assert property (!pop |=> $stable(shift_ff))
    else $error("Shift register moved without a clock edge.");
  cascade_out_a: assert property (ser_out == shift_ff[15])
    else $error("Cascade output differs from last stage.");
  latch_follow_a: assert property (strobe |=> latch_ff == $past(shift_ff))
    else $error("Transparent latch did not follow the register.");
  latch_hold_a: assert property (!strobe ##1 !strobe |=> $stable(latch_ff))
    else $error("Closed latch changed.");
  blank_keep_a: assert property (blank && !strobe |=> $stable(latch_ff))
    else $error("Blanking disturbed the latches.");
  sinks_off_a: assert property (blank |=> sink_on == 16'h0000)
    else $error("Sink on while outputs disabled.");
  sinks_drive_a: assert property (!blank |=> sink_on == $past(latch_ff))
    else $error("Sink does not follow its latch.");
  buffer_bound_a: assert property (count_ff <= BUF_FULL_COUNT && full_ff == (count_ff == 2'h2))
    else $error("Buffer count out of range.");
  buffer_fill_a: assert property (push && !pop |=> count_ff == $past(count_ff) + 2'h1)
    else $error("Buffer did not grow on a lone push.");
  buffer_drain_a: assert property (pop && !push |=> count_ff == $past(count_ff) - 2'h1)
    else $error("Buffer did not shrink on a lone pop.");
  buffer_empty_a: assert property (count_ff == 2'h0 |-> wr_ptr_ff == rd_ptr_ff)
    else $error("Empty buffer with unequal pointers.");
  edge_detect_a: assert property ($rose(sync2_ff.shift_clk) |-> shift_edge)
    else $error("Rising shift clock was not detected.");
  capture_room_a: assert property (shift_edge |-> !full_ff)
    else $error("Captured bit dropped by a full buffer.");
  ready_mirror_a: assert property (!$past(rst) |-> capture_ready == !full_ff)
    else $error("Capture ready disagrees with buffer state.");

  sequence strobe_opening;
    !strobe_prev_ff ##0 strobe;
  endsequence

  strobe_stall_a: assert property (strobe_opening |=> $stable(shift_ff))
    else $error("Shift register moved on the opening strobe cycle.");

  // Reset must quiet the outputs even though the other checks are off during it.
  reset_quiet_a: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> sink_on == SINK_OFF && !ser_out && !capture_ready)
    else $error("Outputs not quiet after reset.");

  ////////////////////////////////////////////////////////////////////////////////
  // Per-channel checks: each sink answers to its own latch bit.

  for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
    latch_bit_a: assert property (strobe |=> latch_ff[c] == $past(shift_ff[c]))
      else $error("Latch bit did not take its own stage.");
    sink_bit_on_a: assert property (!blank && latch_ff[c] |=> sink_on[c])
      else $error("Enabled sink off although its latch holds one.");
    sink_bit_off_a: assert property (!latch_ff[c] |=> !sink_on[c])
      else $error("Sink on although its latch holds zero.");
    sink_bit_blank_a: assert property (blank |=> !sink_on[c])
      else $error("Blanked sink still on.");
  end

endmodule

// ---- hdl/sink_driver_pkg.sv ----
package sink_driver_pkg;

  localparam int CHANNELS = 16;
  localparam int BUF_DEPTH = 2;
  localparam int BUF_WIDTH = 1;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam logic [15:0] SINK_OFF = 16'h0000;
  localparam logic [1:0] BUF_FULL_COUNT = 2'h2;

  typedef logic [CHANNELS-1:0] chan_t;

  // Pin levels from the controller, all asynchronous to clk.
  typedef struct packed {
    logic ser_in;
    logic shift_clk;
    logic latch_strobe;
    logic out_enable_n;
  } pins_s;

endpackage

// ---- tb/host_model.sv ----
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output sink_driver_pkg::pins_s pins
);
  import sink_driver_pkg::*;
  initial pins = '{1'b0, 1'b0, 1'b0, 1'b1};
  // Word goes out most significant bit first; the shift clock rests low between words.
  task automatic send(input chan_t w);
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      pins.ser_in = w[i];
      repeat (4) @(negedge clk);
      pins.shift_clk = 1'b1;
      repeat (4) @(negedge clk);
      pins.shift_clk = 1'b0;
    end
    pins.ser_in = ~w[0];
  endtask
  task automatic level(input logic s, input logic oe_n);
    pins.latch_strobe = s;
    pins.out_enable_n = oe_n;
  endtask
endmodule

// ---- tb/test_serial_latched_sink_driver.sv ----
`timescale 1ns/1ps
module test_serial_latched_sink_driver;
  import sink_driver_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  pins_s pins;
  chan_t sink_on;
  logic ser_out;
  logic capture_ready;
  int n_fail = 0;
  int tests_run = 0;
  logic [31:0] rng = 32'h0000_0017;
  chan_t lat = LATCH_RESET;
  chan_t w;
  chan_t exp_word;
  bit model_q[$];
  always #4 clk = ~clk;
  host_model u_host (.clk(clk), .pins(pins));
  serial_latched_sink_driver u_dut (.clk(clk), .rst(rst), .pins(pins), .sink_on(sink_on),
    .ser_out(ser_out), .capture_ready(capture_ready));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_sink(input chan_t exp);
    for (int i = 0; i < 20 && sink_on !== exp; i++) @(negedge clk);
    check(sink_on, exp);
  endtask
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  // Reference register: the queue keeps the last sixteen bits, oldest in stage 15.
  task automatic model_shift(input chan_t word);
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      model_q.push_back(word[i]);
      if (model_q.size() > CHANNELS) begin
        void'(model_q.pop_front());
      end
    end
    exp_word = '0;
    for (int j = 0; j < model_q.size(); j++) begin
      exp_word[CHANNELS - 1 - j] = model_q[j];
    end
  endtask
  task automatic conclude();
    if (n_fail == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(negedge clk);
    n_fail++;
    conclude();
  end
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check({15'h0000, capture_ready}, 16'h0001);
    u_host.level(1'b0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      rng = xorshift(rng);
      w = rng[15:0];
      u_host.send(w);
      model_shift(w);
      repeat (6) @(negedge clk);
      check(sink_on, lat);
      check({15'h0000, ser_out}, {15'h0000, exp_word[CHANNELS - 1]});
      check({15'h0000, capture_ready}, 16'h0001);
      u_host.level(1'b1, 1'b0);
      repeat (4) @(negedge clk);
      u_host.level(1'b0, 1'b0);
      lat = exp_word;
      wait_sink(lat);
      u_host.level(1'b0, 1'b1);
      wait_sink(SINK_OFF);
      u_host.level(1'b0, 1'b0);
      wait_sink(lat);
    end
    // Latches bypassed: outputs stay blanked while the word moves in.
    u_host.level(1'b1, 1'b1);
    u_host.send(~w);
    model_shift(~w);
    wait_sink(SINK_OFF);
    check({15'h0000, ser_out}, {15'h0000, exp_word[CHANNELS - 1]});
    u_host.level(1'b1, 1'b0);
    wait_sink(exp_word);
    conclude();
  end
endmodule
